// [rtl/abmc_defines.svh]
/*
  Constants for the converter bus and mode control block: decode, word offsets,
  field positions, reset values and sample timing.
  Assumes it is included by its bare name from the design files.
*/
`ifndef ABMC_DEFINES_SVH
`define ABMC_DEFINES_SVH

// ----------------------------------------
// Module base addresses
// ----------------------------------------
`define ABMC_BASE_NORMAL 24'hFFF700
`define ABMC_BASE_ALT 24'h7FF700

// ----------------------------------------
// Word offsets within the 32-word space
// ----------------------------------------
`define ABMC_W_MCR 5'h00
`define ABMC_W_TST 5'h01
`define ABMC_W_RSV0 5'h02
`define ABMC_W_PORT 5'h03
`define ABMC_W_CTL0 5'h04
`define ABMC_W_CTL1 5'h05
`define ABMC_W_STAT 5'h06
`define ABMC_W_RSV1 5'h07
`define ABMC_F_RJU 2'h1
`define ABMC_F_LJS 2'h2
`define ABMC_F_LJU 2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ABMC_MCR_STOP 15
`define ABMC_MCR_FRZ_HI 14
`define ABMC_MCR_FRZ_LO 13
`define ABMC_CTL0_RES10 8
`define ABMC_CTL0_STS_HI 6
`define ABMC_CTL0_STS_LO 5
`define ABMC_CTL0_PRS_HI 4
`define ABMC_CTL0_PRS_LO 0
`define ABMC_CTL1_SCAN 6
`define ABMC_CTL1_MULT 5
`define ABMC_CTL1_S8CM 4
`define ABMC_CTL1_CHAN_HI 3
`define ABMC_CTL1_CHAN_LO 0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ABMC_PRS_RST 5'h03
`define ABMC_STS_RST 2'h0
`define ABMC_SAMPLE_BASE 6'h04
`define ABMC_SAR_MSB 10'h200

`endif

// [rtl/abmc_pkg.sv]
/*
  Types shared by the converter bus and mode control block.
  Assumes the defines header is compiled alongside.
*/
package abmc_pkg;

    // Gray sequence along idle, sample, convert, advance.
    typedef enum logic [1:0] {
        ABMC_IDLE = 2'h0,
        ABMC_SAMPLE = 2'h1,
        ABMC_CONV = 2'h3,
        ABMC_NEXT = 2'h2
    } abmc_state_e;

    typedef enum logic [1:0] {
        ABMC_FRZ_IGNORE = 2'h0,
        ABMC_FRZ_RSV = 2'h1,
        ABMC_FRZ_FINISH = 2'h2,
        ABMC_FRZ_NOW = 2'h3
    } abmc_frz_e;

endpackage

// [rtl/abmc_prescaler.sv]
/*
  Two-stage converter clock prescaler: modulus counter then divide by two.
  Assumes en is low whenever the converter core is stopped or frozen.
*/
`timescale 1ns/1ps
`include "abmc_defines.svh"

module abmc_prescaler #(
    parameter int PW = 5
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    input wire logic [PW-1:0] prescaler_field,
    output logic tick_ff
);

    logic [PW-1:0] cnt_ff;
    logic half_ff;
    wire wrap = (cnt_ff >= prescaler_field);

    // Counter restarts whenever the core clock is gated off.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
            half_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else if (!en) begin
            cnt_ff <= '0;
            half_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else if (wrap) begin
            cnt_ff <= '0;
            half_ff <= ~half_ff;
            tick_ff <= half_ff;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

endmodule

// [rtl/abmc_control.sv]
/*
  Bus slave, register space and conversion sequencing of the converter.
  Assumes a one-cycle bus request strobe and an external comparator that
  answers the current trial code within one converter clock.
*/
`timescale 1ns/1ps
`include "abmc_defines.svh"

module abmc_control #(
    parameter logic [23:0] ALT_BASE = `ABMC_BASE_ALT,
    parameter int NRES = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic [23:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic module_map_bit,
    input wire logic freeze_in,
    input wire logic [7:0] digital_input_pins,
    input wire logic comp_hi,
    output logic bus_ack_ff,
    output logic [15:0] bus_rdata_ff,
    output logic [3:0] mux_chan_ff,
    output logic sample_ff,
    output logic [9:0] dac_code_ff,
    output logic core_run_ff,
    output logic frozen_ff
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic stop_ff;
    logic [1:0] frz_ff;
    logic [15:0] tst_ff;
    logic res10_ff;
    logic [1:0] sts_ff;
    logic [4:0] prs_ff;
    logic scan_ff;
    logic mult_ff;
    logic s8cm_ff;
    logic [3:0] chan_ff;
    logic scf_ff;
    logic [7:0] ccf_ff;
    logic [2:0] idx_ff;
    logic [5:0] cnt_ff;
    logic [9:0] mask_ff;
    logic [9:0] sar_ff;
    logic [9:0] res_mem [0:NRES-1];
    abmc_pkg::abmc_state_e state_ff;
    abmc_pkg::abmc_state_e nxt_state;
    logic [2:0] nxt_idx;
    logic [5:0] nxt_cnt;
    logic [9:0] nxt_mask;
    logic [9:0] nxt_sar;
    logic nxt_scf;
    logic [7:0] nxt_ccf;
    logic store_en;
    logic tick;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire [23:0] base = module_map_bit ? `ABMC_BASE_NORMAL : ALT_BASE;
    wire hit = bus_sel && (bus_addr[23:6] == base[23:6]);
    wire [4:0] widx = bus_addr[5:1];
    wire wr = hit && bus_wr;
    wire wr_mcr = wr && (widx == `ABMC_W_MCR);
    wire wr_tst = wr && (widx == `ABMC_W_TST);
    wire wr_ctl0 = wr && (widx == `ABMC_W_CTL0);
    wire wr_ctl1 = wr && (widx == `ABMC_W_CTL1);
    wire busy = (state_ff != abmc_pkg::ABMC_IDLE);

    // ----------------------------------------
    // Freeze and core clock gating
    // ----------------------------------------
    wire at_boundary = (state_ff == abmc_pkg::ABMC_NEXT) || !busy;
    wire frz_now = (frz_ff == abmc_pkg::ABMC_FRZ_NOW);
    wire frz_fin = (frz_ff == abmc_pkg::ABMC_FRZ_FINISH);
    // The reserved code falls through as ignore.
    wire halt = freeze_in && (frz_now || (frz_fin && at_boundary));
    // Stop only gates the core; the bus side below never looks at it.
    wire run = !stop_ff && !halt && busy;
    wire step = tick && run;

    abmc_prescaler #(
        .PW(5)
    ) u_prescaler (
        .clk(clk),
        .resetn(resetn),
        .en(run),
        .prescaler_field(prs_ff),
        .tick_ff(tick)
    );

    // ----------------------------------------
    // Sequence parameters
    // ----------------------------------------
    wire [5:0] sample_len = `ABMC_SAMPLE_BASE + (6'h04 << sts_ff);
    wire sample_done = (cnt_ff == sample_len - 6'h01);
    wire [9:0] lsb_mask = res10_ff ? 10'h001 : 10'h004;
    wire [9:0] kept = comp_hi ? sar_ff : (sar_ff & ~mask_ff);
    wire [9:0] shr_mask = mask_ff >> 1;
    wire last_bit = (mask_ff == lsb_mask);
    wire [2:0] last_idx = s8cm_ff ? 3'h7 : 3'h3;
    wire [3:0] ch_blk = s8cm_ff ? {chan_ff[3], idx_ff} : {chan_ff[3:2], idx_ff[1:0]};
    // In single-channel mode the channel code passes unchanged to the mux; multichannel mode replaces its low bits with the index.
    wire [3:0] mux_sel = mult_ff ? ch_blk : chan_ff;

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_cnt = cnt_ff;
        nxt_mask = mask_ff;
        nxt_sar = sar_ff;
        nxt_scf = scf_ff;
        nxt_ccf = ccf_ff;
        store_en = 1'b0;
        if (step) begin
            case (state_ff)
                abmc_pkg::ABMC_SAMPLE: begin
                    if (sample_done) begin
                        nxt_state = abmc_pkg::ABMC_CONV;
                        nxt_cnt = 6'h00;
                        nxt_mask = `ABMC_SAR_MSB;
                        nxt_sar = `ABMC_SAR_MSB;
                    end else begin
                        nxt_cnt = cnt_ff + 6'h01;
                    end
                end
                abmc_pkg::ABMC_CONV: begin
                    if (last_bit) begin
                        nxt_sar = kept;
                        store_en = 1'b1;
                        nxt_ccf = ccf_ff | (8'h01 << idx_ff);
                        nxt_state = abmc_pkg::ABMC_NEXT;
                    end else begin
                        nxt_sar = kept | shr_mask;
                        nxt_mask = shr_mask;
                    end
                end
                abmc_pkg::ABMC_NEXT: begin
                    nxt_cnt = 6'h00;
                    if (idx_ff == last_idx) begin
                        nxt_scf = 1'b1;
                        nxt_idx = 3'h0;
                        nxt_state = scan_ff ? abmc_pkg::ABMC_SAMPLE
                                            : abmc_pkg::ABMC_IDLE;
                    end else begin
                        nxt_idx = idx_ff + 3'h1;
                        nxt_state = abmc_pkg::ABMC_SAMPLE;
                    end
                end
                default: begin
                    nxt_state = abmc_pkg::ABMC_IDLE;
                end
            endcase
        end
        if (wr_ctl0 || wr_ctl1) begin
            if (busy) begin
                nxt_scf = 1'b0;
                nxt_ccf = 8'h00;
            end
            nxt_state = abmc_pkg::ABMC_IDLE;
            store_en = 1'b0;
        end
        if (wr_ctl1) begin
            nxt_state = abmc_pkg::ABMC_SAMPLE;
            nxt_idx = 3'h0;
            nxt_cnt = 6'h00;
            nxt_scf = 1'b0;
            nxt_ccf = 8'h00;
        end
        if (stop_ff) begin
            nxt_state = abmc_pkg::ABMC_IDLE;
        end
    end

    // Without a step, a control write or stop, every sequence register holds: a freeze stalls
    // the sequence mid-conversion with ABMC_FRZ_NOW, after the conversion with ABMC_FRZ_FINISH, and it resumes on the next step.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= abmc_pkg::ABMC_IDLE;
            idx_ff <= 3'h0;
            cnt_ff <= 6'h00;
            mask_ff <= 10'h000;
            sar_ff <= 10'h000;
            scf_ff <= 1'b0;
            ccf_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            cnt_ff <= nxt_cnt;
            mask_ff <= nxt_mask;
            sar_ff <= nxt_sar;
            scf_ff <= nxt_scf;
            ccf_ff <= nxt_ccf;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NRES; i++) begin
                res_mem[i] <= 10'h000;
            end
        end else if (store_en) begin
            res_mem[idx_ff] <= kept;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stop_ff <= 1'b1;
            frz_ff <= 2'h0;
            tst_ff <= 16'h0000;
        end else begin
            if (wr_mcr) begin
                stop_ff <= bus_wdata[`ABMC_MCR_STOP];
                frz_ff <= bus_wdata[`ABMC_MCR_FRZ_HI:`ABMC_MCR_FRZ_LO];
            end
            if (wr_tst) begin
                tst_ff <= bus_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            res10_ff <= 1'b0;
            sts_ff <= `ABMC_STS_RST;
            prs_ff <= `ABMC_PRS_RST;
            scan_ff <= 1'b0;
            mult_ff <= 1'b0;
            s8cm_ff <= 1'b0;
            chan_ff <= 4'h0;
        end else begin
            if (wr_ctl0) begin
                res10_ff <= bus_wdata[`ABMC_CTL0_RES10];
                sts_ff <= bus_wdata[`ABMC_CTL0_STS_HI:`ABMC_CTL0_STS_LO];
                prs_ff <= bus_wdata[`ABMC_CTL0_PRS_HI:`ABMC_CTL0_PRS_LO];
            end
            if (wr_ctl1) begin
                scan_ff <= bus_wdata[`ABMC_CTL1_SCAN];
                mult_ff <= bus_wdata[`ABMC_CTL1_MULT];
                s8cm_ff <= bus_wdata[`ABMC_CTL1_S8CM];
                chan_ff <= bus_wdata[`ABMC_CTL1_CHAN_HI:`ABMC_CTL1_CHAN_LO];
            end
        end
    end

    // ----------------------------------------
    // Read data routing
    // ----------------------------------------
    wire [9:0] rv = res_mem[widx[2:0]];
    wire [15:0] r_rju = res10_ff ? {6'h00, rv} : {8'h00, rv[9:2]};
    wire [15:0] r_ljs = {~rv[9], rv[8:0], 6'h00};
    wire [15:0] r_lju = {rv, 6'h00};
    wire [15:0] r_mcr = {stop_ff, frz_ff, 13'h0000};
    wire [15:0] r_ctl0 = {7'h00, res10_ff, 1'b0, sts_ff, prs_ff};
    wire [15:0] r_ctl1 = {9'h000, scan_ff, mult_ff, s8cm_ff, chan_ff};
    wire [15:0] r_stat = {scf_ff, 4'h0, idx_ff, ccf_ff};
    wire [15:0] r_reg = (widx == `ABMC_W_MCR) ? r_mcr :
                        (widx == `ABMC_W_TST) ? tst_ff :
                        (widx == `ABMC_W_PORT) ? {8'h00, digital_input_pins} :
                        (widx == `ABMC_W_CTL0) ? r_ctl0 :
                        (widx == `ABMC_W_CTL1) ? r_ctl1 :
                        (widx == `ABMC_W_STAT) ? r_stat : 16'h0000;
    wire [15:0] r_res = (widx[4:3] == `ABMC_F_RJU) ? r_rju :
                        (widx[4:3] == `ABMC_F_LJS) ? r_ljs : r_lju;
    wire [15:0] rdata = (widx[4:3] == 2'h0) ? r_reg : r_res;

    // Every addressed cycle ends in one ack, stopped or not.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_ack_ff <= 1'b0;
            bus_rdata_ff <= 16'h0000;
        end else begin
            bus_ack_ff <= hit;
            bus_rdata_ff <= (hit && !bus_wr) ? rdata : 16'h0000;
        end
    end

    // ----------------------------------------
    // Analog side outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mux_chan_ff <= 4'h0;
            sample_ff <= 1'b0;
            dac_code_ff <= 10'h000;
            core_run_ff <= 1'b0;
            frozen_ff <= 1'b0;
        end else begin
            mux_chan_ff <= mux_sel;
            sample_ff <= (nxt_state == abmc_pkg::ABMC_SAMPLE);
            dac_code_ff <= nxt_sar;
            core_run_ff <= run;
            frozen_ff <= halt && busy;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_ACK_EVERY_HIT: assert property (hit |=> bus_ack_ff)
        else $error("addressed cycle not acknowledged");
    AST_STOP_AT_RESET: assert property ($rose(resetn) |-> stop_ff)
        else $error("stop bit clear after reset");
    AST_STOP_IDLE: assert property (stop_ff |=> state_ff == abmc_pkg::ABMC_IDLE)
        else $error("sequence running while stopped");
    AST_CTL0_HALTS: assert property (wr_ctl0 && !wr_ctl1 |=> !busy)
        else $error("first control write did not halt");
    AST_CTL1_STARTS: assert property (wr_ctl1 && !stop_ff |=>
        state_ff == abmc_pkg::ABMC_SAMPLE && ccf_ff == 8'h00 && !scf_ff)
        else $error("second control write did not start cleanly");
    AST_FREEZE_HOLD: assert property (freeze_in && frz_now && !wr_ctl0 && !wr_ctl1
        |=> $stable(sar_ff) && $stable(cnt_ff) && $stable(idx_ff))
        else $error("sequence moved while frozen");
    AST_RSV_ZERO: assert property (hit && !bus_wr && widx == `ABMC_W_RSV1
        |=> bus_rdata_ff == 16'h0000)
        else $error("reserved word read nonzero");
    AST_PORT_READ: assert property (hit && !bus_wr && widx == `ABMC_W_PORT
        |=> bus_rdata_ff == {8'h00, $past(digital_input_pins)})
        else $error("port read mismatch");
    AST_IGNORE_NO_FREEZE: assert property (!frz_ff[1] |=> !frozen_ff)
        else $error("froze with ignore or reserved code");
    AST_SAMPLE_LEN: assert property (state_ff == abmc_pkg::ABMC_SAMPLE
        |-> cnt_ff < sample_len)
        else $error("sample count beyond selected length");

    COV_START: cover property (wr_ctl1 && !stop_ff);
    COV_SEQ_DONE: cover property ($rose(scf_ff));
    COV_FROZEN: cover property (frozen_ff && state_ff == abmc_pkg::ABMC_CONV);
    COV_STOP_ABORT: cover property (busy && wr_mcr && bus_wdata[`ABMC_MCR_STOP]);

endmodule

// [verif/abmc_comp_model.sv]
/*
  Behavioural comparator and analog front end facing the converter control block.
  Assumes the bench fills the level table before any conversion starts.
*/
`timescale 1ns/1ps

module abmc_comp_model (
    input wire logic clk,
    input wire logic sample_ff,
    input wire logic [3:0] mux_chan_ff,
    input wire logic [9:0] dac_code_ff,
    output logic comp_hi
);
    // ----------------------------------------
    // Source levels and sample hold
    // ----------------------------------------
    logic [9:0] level [16];
    logic [9:0] held_ff = 10'h000;

    // The held level follows the selected source only while sampling, as a real hold would.
    always @(posedge clk) begin
        if (sample_ff === 1'b1) begin
            held_ff <= level[mux_chan_ff];
        end
    end

    assign comp_hi = (held_ff >= dac_code_ff);
endmodule

// [verif/tb_top.sv]
/*
  Self-checking bench for the converter bus and mode control block.
  Assumes the design files and the comparator model are compiled first.
*/
`timescale 1ns/1ps

module tb_top;
    // ----------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------
    logic clk = 0;
    logic resetn = 0;
    logic bus_sel = 0;
    logic bus_wr = 0;
    logic [23:0] bus_addr = 24'h000000;
    logic [15:0] bus_wdata = 16'h0000;
    logic module_map_bit = 1;
    logic freeze_in = 0;
    logic [7:0] digital_input_pins = 8'h00;
    logic comp_hi, bus_ack_ff, sample_ff, core_run_ff, frozen_ff;
    logic [15:0] bus_rdata_ff;
    logic [3:0] mux_chan_ff;
    logic [9:0] dac_code_ff;
    logic [23:0] base = 24'hFFF700;
    logic [31:0] expq [$];
    logic [31:0] e;
    logic [9:0] d;
    logic r10 = 1;
    int mismatches = 0;
    int comparisons = 0;
    int unsigned seed;

    always #2.5 clk = ~clk;

    abmc_control dut (.clk(clk), .resetn(resetn), .bus_sel(bus_sel), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .module_map_bit(module_map_bit),
        .freeze_in(freeze_in), .digital_input_pins(digital_input_pins), .comp_hi(comp_hi),
        .bus_ack_ff(bus_ack_ff), .bus_rdata_ff(bus_rdata_ff), .mux_chan_ff(mux_chan_ff),
        .sample_ff(sample_ff), .dac_code_ff(dac_code_ff), .core_run_ff(core_run_ff),
        .frozen_ff(frozen_ff));

    abmc_comp_model u_comp (.clk(clk), .sample_ff(sample_ff), .mux_chan_ff(mux_chan_ff),
        .dac_code_ff(dac_code_ff), .comp_hi(comp_hi));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A miss pushes no note, so any ack it raises shows up as an unexpected one.
    task automatic access(input logic is_wr, input logic [23:0] a, input logic [15:0] dt,
            input logic hit, input logic [15:0] exp, input logic [15:0] m);
        bus_sel = 1;
        bus_wr = is_wr;
        bus_addr = a;
        bus_wdata = dt;
        if (hit) expq.push_back({m, is_wr ? 16'h0000 : exp});
        @(posedge clk);
        #1;
        bus_sel = 0;
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] w, input logic [15:0] dt);
        access(1, base + {18'h0, w, 1'b0}, dt, 1, 16'h0000, 16'hFFFF);
    endtask

    task automatic rd(input logic [4:0] w, input logic [15:0] exp, input logic [15:0] m);
        access(0, base + {18'h0, w, 1'b0}, 16'h0000, 1, exp, m);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        // A freeze released just before still shows as not running for one edge.
        repeat (2) @(posedge clk);
        while (core_run_ff !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        #1;
        check("idle", {15'h0, core_run_ff}, 16'h0000);
    endtask

    task automatic wait_compare();
        int n;
        n = 0;
        while (sample_ff !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        while (sample_ff !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        #1;
    endtask

    // Results are worked out from the model's source table, never from the design.
    task automatic results(input logic [15:0] c1);
        int n;
        int i;
        logic [3:0] ch;
        logic [9:0] v;
        n = c1[4] ? 8 : 4;
        wait_idle();
        rd(5'h06, (n == 8) ? 16'h80FF : 16'h800F, 16'h80FF);
        for (i = 0; i < n; i++) begin
            ch = !c1[5] ? c1[3:0] : ((n == 8) ? {c1[3], 3'(i)} : {c1[3:2], 2'(i)});
            v = u_comp.level[ch] & (r10 ? 10'h3FF : 10'h3FC);
            rd(5'(8 + i), r10 ? {6'h00, v} : {8'h00, v[9:2]}, 16'hFFFF);
            rd(5'(16 + i), {~v[9], v[8:0], 6'h00}, 16'hFFFF);
            rd(5'(24 + i), {v, 6'h00}, 16'hFFFF);
        end
    endtask

    task automatic conv(input logic [15:0] c1);
        wr(5'h05, c1);
        results(c1);
    endtask

    // ----------------------------------------
    // Result monitor
    // ----------------------------------------
    always @(posedge clk) begin
        if (resetn === 1'b1 && bus_ack_ff === 1'b1) begin
            if (expq.size() == 0) begin
                check("unexpected ack", 16'h0001, 16'h0000);
            end else begin
                e = expq.pop_front();
                check("read data", bus_rdata_ff & e[31:16], e[15:0] & e[31:16]);
            end
        end
    end

    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = $urandom(37);
        for (int k = 0; k < 16; k++) u_comp.level[k] = 10'($urandom);
        u_comp.level[12] = 10'h3FF;
        u_comp.level[13] = 10'h000;
        u_comp.level[14] = 10'h200;
        repeat (4) @(posedge clk);
        #1;
        resetn = 1;
        rd(5'h00, 16'h8000, 16'hFFFF);
        rd(5'h04, 16'h0003, 16'h007F);
        wr(5'h01, 16'hA5C3);
        rd(5'h01, 16'hA5C3, 16'hFFFF);
        wr(5'h02, 16'hFFFF);
        rd(5'h02, 16'h0000, 16'hFFFF);
        wr(5'h07, 16'hFFFF);
        rd(5'h07, 16'h0000, 16'hFFFF);
        digital_input_pins = 8'($urandom);
        rd(5'h03, {8'h00, digital_input_pins}, 16'hFFFF);
        access(0, 24'hFFF740, 16'h0000, 0, 16'h0000, 16'h0000);
        module_map_bit = 0;
        access(0, 24'hFFF700, 16'h0000, 0, 16'h0000, 16'h0000);
        base = 24'h7FF700;
        rd(5'h00, 16'h8000, 16'hFFFF);
        module_map_bit = 1;
        base = 24'hFFF700;
        wr(5'h05, 16'h0005);
        repeat (10) @(posedge clk);
        #1;
        check("run while stopped", {15'h0, core_run_ff}, 16'h0000);
        rd(5'h05, 16'h0005, 16'h007F);
        wr(5'h00, 16'h0000);
        wr(5'h04, 16'h0101);
        conv(16'h0005);
        conv(16'h000F);
        conv(16'h0030);
        conv(16'h002C);
        wr(5'h05, 16'h0005);
        repeat (20) @(posedge clk);
        #1;
        wr(5'h00, 16'h8000);
        check("stop abort", {15'h0, core_run_ff}, 16'h0000);
        rd(5'h06, 16'h0000, 16'h80FF);
        wr(5'h00, 16'h0000);
        wr(5'h04, 16'h0061);
        r10 = 0;
        conv(16'h0010);
        r10 = 1;
        wr(5'h04, 16'h0101);
        for (int k = 0; k < 2; k++) begin
            wr(5'h00, {1'b0, 2'(k), 13'h0000});
            freeze_in = 1;
            wr(5'h05, 16'h0005);
            repeat (30) @(posedge clk);
            #1;
            check("frozen", {15'h0, frozen_ff}, 16'h0000);
            results(16'h0005);
            freeze_in = 0;
        end
        wr(5'h00, 16'h6000);
        wr(5'h05, 16'h0005);
        wait_compare();
        repeat (8) @(posedge clk);
        #1;
        freeze_in = 1;
        repeat (3) @(posedge clk);
        #1;
        check("frozen", {15'h0, frozen_ff}, 16'h0001);
        check("run", {15'h0, core_run_ff}, 16'h0000);
        d = dac_code_ff;
        repeat (20) @(posedge clk);
        #1;
        check("trial code", {6'h00, dac_code_ff}, {6'h00, d});
        freeze_in = 0;
        results(16'h0005);
        wr(5'h00, 16'h4000);
        wr(5'h05, 16'h0005);
        wait_compare();
        repeat (8) @(posedge clk);
        #1;
        freeze_in = 1;
        repeat (3) @(posedge clk);
        #1;
        check("frozen early", {15'h0, frozen_ff}, 16'h0000);
        repeat (300) @(posedge clk);
        #1;
        check("frozen late", {15'h0, frozen_ff}, 16'h0001);
        freeze_in = 0;
        results(16'h0005);
        wr(5'h00, 16'h0000);
        wr(5'h05, 16'h0045);
        repeat (1500) @(posedge clk);
        #1;
        check("scan run", {15'h0, core_run_ff}, 16'h0001);
        wr(5'h04, 16'h0101);
        check("halted", {15'h0, core_run_ff}, 16'h0000);
        rd(5'h06, 16'h0000, 16'h80FF);
        conv(16'h0005);
        repeat (4) @(posedge clk);
        check("pending", 16'(expq.size()), 16'h0000);
        give_verdict();
    end
endmodule
